// File: rcfg_pkg.sv
// constants, offsets and reset values for the reader configuration bank
package rcfg_pkg;

    // register offsets
    localparam logic [7:0] OFF_RSVD_A      = 8'h1a;
    localparam logic [7:0] OFF_RSVD_B      = 8'h1b;
    localparam logic [7:0] OFF_TX_TIMING   = 8'h1c;
    localparam logic [7:0] OFF_RX_PARITY   = 8'h1d;
    localparam logic [7:0] OFF_RSVD_C      = 8'h1e;
    localparam logic [7:0] OFF_SERIAL_RATE = 8'h1f;
    localparam logic [7:0] OFF_RSVD_D      = 8'h20;
    localparam logic [7:0] OFF_CRC_HIGH    = 8'h21;
    localparam logic [7:0] OFF_CRC_LOW     = 8'h22;
    localparam logic [7:0] OFF_RSVD_E      = 8'h23;
    localparam logic [7:0] OFF_MOD_WIDTH   = 8'h24;
    localparam logic [7:0] OFF_RSVD_F      = 8'h25;
    localparam logic [7:0] OFF_RX_GAIN     = 8'h26;
    localparam logic [7:0] OFF_N_COND      = 8'h27;
    localparam logic [7:0] OFF_P_IDLE      = 8'h28;
    localparam logic [7:0] OFF_P_MOD       = 8'h29;
    localparam logic [7:0] OFF_TIMER_MODE  = 8'h2a;
    localparam logic [7:0] OFF_DIVIDER_LO  = 8'h2b;
    localparam logic [7:0] OFF_RELOAD_HI   = 8'h2c;
    localparam logic [7:0] OFF_RELOAD_LO   = 8'h2d;
    localparam logic [7:0] OFF_DEMOD       = 8'h19;
    localparam logic [7:0] OFF_CONTROL     = 8'h0c;
    localparam logic [7:0] OFF_STATUS      = 8'h08;

    // reset values
    localparam logic [7:0] RST_ZERO        = 8'h00;
    localparam logic [7:0] RST_TX_TIMING   = 8'h62;
    localparam logic [7:0] RST_SERIAL_RATE = 8'heb;
    localparam logic [7:0] RST_CRC         = 8'hff;
    localparam logic [7:0] RST_RSVD_E      = 8'h88;
    localparam logic [7:0] RST_MOD_WIDTH   = 8'h26;
    localparam logic [7:0] RST_RSVD_F      = 8'h87;
    localparam logic [7:0] RST_RX_GAIN     = 8'h48;
    localparam logic [7:0] RST_N_COND      = 8'h88;
    localparam logic [7:0] RST_P_COND      = 8'h20;

    // writable-bit masks; other bits read zero after a write, except tx timing bits 6:5
    localparam logic [7:0] MSK_TX_TIMING   = 8'h03;
    localparam logic [7:0] MSK_RX_PARITY   = 8'h10;
    localparam logic [7:0] MSK_RX_GAIN     = 8'h70;
    localparam logic [7:0] MSK_P_COND      = 8'h3f;

    // field positions
    localparam int POS_TMODE_AUTO    = 7;
    localparam int POS_TMODE_RELOAD  = 4;
    localparam int POS_DEMOD_FIX     = 5;
    localparam int POS_DEMOD_EVEN    = 4;
    localparam int POS_CTRL_STOP     = 7;
    localparam int POS_CTRL_START    = 6;
    localparam int POS_ST_CRC_DONE   = 5;
    localparam int POS_ST_RUNNING    = 3;
    localparam int POS_ST_TIMER_IRQ  = 0;

    // received bits before an automatic stop
    localparam logic [2:0] AUTO_STOP_BITS = 3'h5;

    // timer run states
    typedef enum logic [1:0] {TMR_IDLE, TMR_RUN, TMR_DONE} tmr_state_t;

endpackage

// File: rcfg_timer.sv
// prescaled down-counting timer with reload and gating
`timescale 1ns/1ps
module rcfg_timer
    import rcfg_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        resetn,
    // settings
    input  wire logic [11:0] timer_divider_value,
    input  wire logic        prescaler_even_select,
    input  wire logic        timer_auto_reload,
    input  wire logic [15:0] reload_value,
    input  wire logic        gate_open,
    // controls
    input  wire logic        start_req,
    input  wire logic        stop_req,
    // state
    output logic             running,
    output logic             expire_pulse,
    output logic [15:0]      count
);

    typedef struct packed {
        tmr_state_t  st;
        logic [12:0] pre;
        logic [15:0] cnt;
        logic        exp;
    } tmr_t;

    tmr_t s_r;
    tmr_t s_nxt;

    // prescaler terminal count: 2n for odd divide, 2n+1 for even divide
    function automatic logic [12:0] pre_top(input logic [11:0] n,
                                            input logic        even);
        pre_top = {n, 1'b0} + {12'h000, even};
    endfunction

    // next-state logic
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.exp = 1'b0;
        case (s_r.st)
            TMR_IDLE, TMR_DONE:
            begin
                if (start_req)
                begin
                    s_nxt.st  = TMR_RUN;
                    s_nxt.cnt = reload_value;
                    s_nxt.pre = 13'h0000;
                end
            end
            TMR_RUN:
            begin
                if (stop_req)
                    s_nxt.st = TMR_IDLE;
                else if (gate_open)
                begin
                    // tick every (2n+1) or (2n+2) clocks
                    if (s_r.pre >= pre_top(timer_divider_value,
                                           prescaler_even_select)) // R2 R3
                    begin
                        s_nxt.pre = 13'h0000;
                        if (s_r.cnt == 16'h0000)
                        begin
                            s_nxt.exp = 1'b1;
                            if (timer_auto_reload)
                                s_nxt.cnt = reload_value; // R21
                            else
                                s_nxt.st = TMR_DONE; // R22
                        end
                        else
                            s_nxt.cnt = s_r.cnt - 16'h0001;
                    end
                    else
                        s_nxt.pre = s_r.pre + 13'h0001;
                end
            end
            default:
                s_nxt.st = TMR_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            s_r <= '{TMR_IDLE, 13'h0000, 16'h0000, 1'b0};
        else
            s_r <= s_nxt;
    end

    assign running      = (s_r.st == TMR_RUN);
    assign expire_pulse = s_r.exp;
    assign count        = s_r.cnt;

endmodule // rcfg_timer

// File: rcfg_regs.sv
// reader configuration and timer-mode register bank
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Operation
// (R1) fixed channel: low select bit picks I/Q
// (R2) even-select 0: timer clock divides 2n+1
// (R3) even-select 1: timer clock divides 2n+2
// (R4) divider upper nibble from timer mode
// (R5) receive loop constant 00 freezes PLL
// (R6) burst loop constant sets PLL during burst
// (R7) response time field, reset 62h
// (R8) parity off: no generate, no check
// (R9) serial rate coarse and fine factors
// (R10) checksum bytes read-only, reset FFh
// (R11) modulation pulse lasts width plus one
// (R12) receiver gain code selects dB gain
// (R13) n-driver idle and modulation strengths
// (R14) p-driver idle strength, power-down forces top
// (R15) force full ask overrides p-mod strength
// (R16) auto timer starts at transmit end
// (R17) single frame: stop at fifth bit
// (R18) multi frame: only host stops timer
// (R19) auto off: protocol never touches timer
// (R20) gating selection; running reads one
// (R21) auto reload restarts from reload value
// (R22) no reload: stop at zero, flag
// (R23) reserved registers fixed, reserved bits zero; tx timing bits 6:5 read one, rx gain bit 3 reads one until written
// (R24) reset values; writes act next clock
module rcfg_regs
    import rcfg_pkg::*;
(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       resetn,
    // register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // protocol events
    input  wire logic       tx_end,
    input  wire logic       rx_bit,
    input  wire logic       multi_frame_receive,
    input  wire logic       soft_power_down,
    input  wire logic       driver_on,
    input  wire logic [1:0] gate_inputs,
    // checksum engine
    input  wire logic [15:0] checksum_value,
    input  wire logic        checksum_load,
    input  wire logic        checksum_done_flag,
    // analogue controls
    output logic            receive_q_channel,
    output logic            fixed_channel_enable,
    output logic            pll_frozen,
    output logic      [1:0] burst_loop_time_constant,
    output logic      [1:0] receive_loop_time_constant,
    output logic      [1:0] extra_response_time,
    output logic            parity_off,
    output logic      [2:0] serial_rate_coarse,
    output logic      [4:0] serial_rate_fine,
    output logic      [7:0] pulse_width_value,
    output logic      [5:0] receiver_gain_db,
    output logic      [3:0] n_drive_idle_strength,
    output logic      [3:0] n_drive_mod_strength,
    output logic      [5:0] p_drive_idle_strength,
    output logic      [5:0] p_drive_mod_strength,
    output logic            full_ask_active,
    output logic            timer_running_flag,
    output logic            timer_interrupt_flag
);

    typedef struct packed {
        logic [7:0]  tx_timing;
        logic [7:0]  rx_parity;
        logic [7:0]  serial_rate;
        logic [7:0]  crc_hi;
        logic [7:0]  crc_lo;
        logic [7:0]  mod_width;
        logic [7:0]  rx_gain;
        logic [7:0]  n_cond;
        logic [7:0]  p_idle;
        logic [7:0]  p_mod;
        logic [7:0]  tmode;
        logic [7:0]  div_lo;
        logic [15:0] reload;
        logic [7:0]  demod;
        logic        force_ask;
        logic        tmr_irq;
        logic [2:0]  rx_bits;
        logic        rx_active;
        logic [7:0]  rdata;
        logic        start_p;
        logic        stop_p;
        logic [53:0] outs;
    } bank_t;

    bank_t s_r;
    bank_t s_nxt;

    logic        tmr_running;
    logic        tmr_expire;
    logic        gate_open;

    // map gain code onto dB
    function automatic logic [5:0] gain_db(input logic [2:0] code);
        case (code)
            3'h0, 3'h2: gain_db = 6'h12;
            3'h1, 3'h3: gain_db = 6'h17;
            3'h4:       gain_db = 6'h21;
            3'h5:       gain_db = 6'h26;
            3'h6:       gain_db = 6'h2b;
            default:    gain_db = 6'h30;
        endcase // R12
    endfunction

    // top bit forced high in soft power-down
    function automatic logic [5:0] pd_force(input logic [5:0] v,
                                            input int         top,
                                            input logic       pd);
        pd_force = v;
        if (pd)
            pd_force[top] = 1'b1;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // gating: 00 free, 01/10 pick a gate input, 11 held off
    always_comb
    begin
        case (s_r.tmode[6:5])
            2'h0:    gate_open = 1'b1;
            2'h1:    gate_open = gate_inputs[0];
            2'h2:    gate_open = gate_inputs[1];
            default: gate_open = 1'b0;
        endcase // R20
    end

    rcfg_timer u_timer (
        .core_clk              (core_clk),
        .resetn                (resetn),
        .timer_divider_value   ({s_r.tmode[3:0], s_r.div_lo}), // R4
        .prescaler_even_select (s_r.demod[POS_DEMOD_EVEN]),
        .timer_auto_reload     (s_r.tmode[POS_TMODE_RELOAD]),
        .reload_value          (s_r.reload),
        .gate_open             (gate_open),
        .start_req             (s_r.start_p),
        .stop_req              (s_r.stop_p),
        .running               (tmr_running),
        .expire_pulse          (tmr_expire),
        .count                 ()
    );

    ////////////////////////////////////////////////////////////////////////////
    // register writes, protocol hooks and read mux
    always_comb
    begin
        logic       wr;
        logic       auto;
        logic       pd;
        logic [5:0] pmod;
        logic [3:0] nidle;
        logic [3:0] nmod;
        wr   = 1'b0;
        auto = 1'b0;
        pd   = 1'b0;
        pmod = 6'h00;
        nidle = 4'h0;
        nmod  = 4'h0;
        s_nxt = s_r;
        s_nxt.start_p = 1'b0;
        s_nxt.stop_p  = 1'b0;
        wr   = reg_wr;
        auto = s_r.tmode[POS_TMODE_AUTO];
        pd   = soft_power_down;
        if (wr)
        begin
            case (reg_addr) // R23 R24
                OFF_TX_TIMING:   s_nxt.tx_timing = reg_wdata & MSK_TX_TIMING
                                                  | 8'h60; // R7
                OFF_RX_PARITY:   s_nxt.rx_parity = reg_wdata & MSK_RX_PARITY;
                OFF_SERIAL_RATE: s_nxt.serial_rate = reg_wdata; // R9
                OFF_MOD_WIDTH:   s_nxt.mod_width = reg_wdata; // R11
                OFF_RX_GAIN:     s_nxt.rx_gain = reg_wdata & MSK_RX_GAIN;
                OFF_N_COND:      s_nxt.n_cond = reg_wdata; // R13
                OFF_P_IDLE:      s_nxt.p_idle = reg_wdata & MSK_P_COND;
                OFF_P_MOD:       s_nxt.p_mod = reg_wdata & MSK_P_COND;
                OFF_TIMER_MODE:  s_nxt.tmode = reg_wdata;
                OFF_DIVIDER_LO:  s_nxt.div_lo = reg_wdata;
                OFF_RELOAD_HI:   s_nxt.reload[15:8] = reg_wdata;
                OFF_RELOAD_LO:   s_nxt.reload[7:0] = reg_wdata;
                OFF_DEMOD:       s_nxt.demod = reg_wdata;
                OFF_CONTROL:
                begin
                    s_nxt.force_ask = reg_wdata[0];
                    s_nxt.stop_p    = reg_wdata[POS_CTRL_STOP]; // R18
                    s_nxt.start_p   = reg_wdata[POS_CTRL_START];
                end
                default: ;
            endcase
        end
        // checksum bytes only from the engine
        if (checksum_load)
            {s_nxt.crc_hi, s_nxt.crc_lo} = checksum_value; // R10
        // protocol-linked start and stop only with auto set
        if (auto) // R19
        begin
            if (tx_end)
            begin
                s_nxt.start_p   = 1'b1; // R16
                s_nxt.rx_bits   = 3'h0;
                s_nxt.rx_active = 1'b1;
            end
            else if (rx_bit && s_r.rx_active)
            begin
                s_nxt.rx_bits = s_r.rx_bits + 3'h1;
                if (!multi_frame_receive &&
                    (s_r.rx_bits + 3'h1) == AUTO_STOP_BITS)
                begin
                    s_nxt.stop_p    = 1'b1; // R17
                    s_nxt.rx_active = 1'b0;
                end
            end
        end
        // expiry without reload sets the flag; a clearing write loses to it
        if (wr && reg_addr == OFF_STATUS && reg_wdata[POS_ST_TIMER_IRQ])
            s_nxt.tmr_irq = 1'b0;
        if (tmr_expire && !s_r.tmode[POS_TMODE_RELOAD])
            s_nxt.tmr_irq = 1'b1; // R22
        // read data valid only the cycle after the strobe
        s_nxt.rdata = 8'h00;
        if (reg_rd)
        begin
            case (reg_addr)
                OFF_RSVD_A, OFF_RSVD_B, OFF_RSVD_C, OFF_RSVD_D:
                                 s_nxt.rdata = RST_ZERO; // R23
                OFF_RSVD_E:      s_nxt.rdata = RST_RSVD_E;
                OFF_RSVD_F:      s_nxt.rdata = RST_RSVD_F;
                OFF_TX_TIMING:   s_nxt.rdata = s_r.tx_timing;
                OFF_RX_PARITY:   s_nxt.rdata = s_r.rx_parity;
                OFF_SERIAL_RATE: s_nxt.rdata = s_r.serial_rate;
                OFF_CRC_HIGH:    s_nxt.rdata = s_r.crc_hi;
                OFF_CRC_LOW:     s_nxt.rdata = s_r.crc_lo;
                OFF_MOD_WIDTH:   s_nxt.rdata = s_r.mod_width;
                OFF_RX_GAIN:     s_nxt.rdata = s_r.rx_gain;
                OFF_N_COND:      s_nxt.rdata = s_r.n_cond;
                OFF_P_IDLE:      s_nxt.rdata = s_r.p_idle;
                OFF_P_MOD:       s_nxt.rdata = s_r.p_mod;
                OFF_TIMER_MODE:  s_nxt.rdata = s_r.tmode;
                OFF_DIVIDER_LO:  s_nxt.rdata = s_r.div_lo;
                OFF_RELOAD_HI:   s_nxt.rdata = s_r.reload[15:8];
                OFF_RELOAD_LO:   s_nxt.rdata = s_r.reload[7:0];
                OFF_DEMOD:       s_nxt.rdata = s_r.demod;
                OFF_CONTROL:     s_nxt.rdata = {7'h00, s_r.force_ask};
                OFF_STATUS:      s_nxt.rdata = {2'h0, checksum_done_flag,
                                                1'b0, tmr_running,
                                                2'h0, s_r.tmr_irq}; // R20
                default:         s_nxt.rdata = 8'h00;
            endcase
        end
        // registered analogue controls
        pmod = s_r.p_mod[5:0];
        if (s_r.force_ask)
            pmod = 6'h00; // R15
        // n-driver strengths only count while a driver is on
        if (driver_on)
        begin
            nidle = {pd | s_r.n_cond[7], s_r.n_cond[6:4]}; // R13 R14
            nmod  = {pd | s_r.n_cond[3], s_r.n_cond[2:0]};
        end
        s_nxt.outs = {
            s_r.demod[6],                                   // R1
            s_r.demod[POS_DEMOD_FIX],
            s_r.demod[3:2] == 2'h0,                         // R5
            s_r.demod[1:0],                                 // R6
            s_r.demod[3:2],
            s_r.tx_timing[1:0],
            s_r.rx_parity[4],                               // R8
            s_r.serial_rate[7:5],
            s_r.serial_rate[4:0],
            s_r.mod_width,
            gain_db(s_r.rx_gain[6:4]),
            nidle,
            nmod,
            pd_force(s_r.p_idle[5:0], 5, pd),               // R14
            pd_force(pmod, 5, pd),
            s_r.force_ask,
            tmr_running
        };
    end

    // state register
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_r             <= '0;
            s_r.tx_timing   <= RST_TX_TIMING;
            s_r.serial_rate <= RST_SERIAL_RATE;
            s_r.crc_hi      <= RST_CRC;
            s_r.crc_lo      <= RST_CRC;
            s_r.mod_width   <= RST_MOD_WIDTH;
            s_r.rx_gain     <= RST_RX_GAIN;
            s_r.n_cond      <= RST_N_COND;
            s_r.p_idle      <= RST_P_COND;
            s_r.p_mod       <= RST_P_COND;
        end
        else
            s_r <= s_nxt;
    end

    assign reg_rdata = s_r.rdata;
    assign {receive_q_channel, fixed_channel_enable, pll_frozen,
            burst_loop_time_constant, receive_loop_time_constant,
            extra_response_time, parity_off, serial_rate_coarse,
            serial_rate_fine, pulse_width_value, receiver_gain_db,
            n_drive_idle_strength, n_drive_mod_strength,
            p_drive_idle_strength, p_drive_mod_strength,
            full_ask_active, timer_running_flag}
           = s_r.outs;
    assign timer_interrupt_flag  = s_r.tmr_irq;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    chk_reset_tx_timing: assert property (@(posedge core_clk) // R7
        $rose(resetn) |-> s_r.tx_timing == RST_TX_TIMING)
        else $error("tx timing reset value wrong");
    chk_write_lands: assert property (@(posedge core_clk) // R24
        disable iff (!resetn)
        reg_wr && reg_addr == OFF_MOD_WIDTH |=> s_r.mod_width == $past(reg_wdata))
        else $error("write not applied next clock");
    chk_rsvd_reads: assert property (@(posedge core_clk) // R23
        disable iff (!resetn)
        reg_rd && reg_addr == OFF_RSVD_F |=> reg_rdata == RST_RSVD_F)
        else $error("reserved register read wrong");
    chk_auto_start: assert property (@(posedge core_clk) // R16
        disable iff (!resetn)
        tx_end && s_r.tmode[7] |=> s_r.start_p)
        else $error("auto start missing");
    chk_no_auto: assert property (@(posedge core_clk) // R19
        disable iff (!resetn)
        !s_r.tmode[7] && !(reg_wr && reg_addr == OFF_CONTROL) |=> !s_r.start_p)
        else $error("protocol touched timer");
    chk_multi_no_stop: assert property (@(posedge core_clk) // R18
        disable iff (!resetn)
        multi_frame_receive && !(reg_wr && reg_addr == OFF_CONTROL)
        |=> !s_r.stop_p)
        else $error("timer stopped in multi frame");
    chk_irq_set: assert property (@(posedge core_clk) // R22
        disable iff (!resetn)
        tmr_expire && !s_r.tmode[4] |=> timer_interrupt_flag)
        else $error("expiry flag not set");
    chk_crc_ro: assert property (@(posedge core_clk) // R10
        disable iff (!resetn)
        !checksum_load |=> $stable(s_r.crc_hi))
        else $error("checksum byte changed by host");
    cov_auto_start: cover property (@(posedge core_clk) s_r.start_p);
    cov_expire: cover property (@(posedge core_clk) tmr_expire);
    cov_fifth_stop: cover property (@(posedge core_clk)
        s_r.stop_p && s_r.tmode[7]);

endmodule // rcfg_regs

// File: rcfg_host_model.sv
// host controller model driving the register port
`timescale 1ns/1ps
module rcfg_host_model
(
    // clock
    input  wire logic       core_clk,
    // register port
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    // idle bus at time zero
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // one-cycle write strobe, no wait states
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
endmodule // rcfg_host_model

// File: reader_config_timer_regs_tb.sv
// self-checking bench for the configuration and timer-mode bank
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin fails++; \
    $display("[FAIL] %s exp %h got %h", n, e, a); end end
module reader_config_timer_regs_tb;
    import rcfg_pkg::*;
    logic core_clk = 1'b0, resetn = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
    logic reg_wr, reg_rd, tx_end = 0, rx_bit = 0, mfr = 0, spd = 0;
    logic drv = 1, ck_ld = 0, ck_done = 0;
    logic [1:0] gate = 2'h0;
    logic [15:0] ck_val = 16'h0000;
    logic [7:0] pw;
    logic [5:0] gain, p_idle, p_mod;
    logic [3:0] n_idle, n_mod;
    logic [1:0] ert, bls, rls;
    logic [2:0] coarse;
    logic [4:0] fine;
    logic q_ch, fix, par, run, tirq, pll, fask;
    int fails = 0, checked = 0, seed = 72, exp_v[256], msk[256], a, i;
    int db[8] = '{18, 23, 18, 23, 33, 38, 43, 48};
    ////////////////////////////////////////////////////////////////////
    initial forever #50 core_clk = ~core_clk;
    rcfg_host_model u_rcfg_host_model (.core_clk(core_clk),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    rcfg_regs u_rcfg_regs (.core_clk(core_clk), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_end(tx_end),
        .rx_bit(rx_bit), .multi_frame_receive(mfr),
        .soft_power_down(spd), .driver_on(drv), .gate_inputs(gate),
        .checksum_value(ck_val), .checksum_load(ck_ld),
        .checksum_done_flag(ck_done), .receive_q_channel(q_ch),
        .fixed_channel_enable(fix), .pll_frozen(pll),
        .burst_loop_time_constant(bls), .receive_loop_time_constant(rls),
        .extra_response_time(ert), .parity_off(par),
        .serial_rate_coarse(coarse), .serial_rate_fine(fine),
        .pulse_width_value(pw), .receiver_gain_db(gain),
        .n_drive_idle_strength(n_idle), .n_drive_mod_strength(n_mod),
        .p_drive_idle_strength(p_idle), .p_drive_mod_strength(p_mod),
        .full_ask_active(fask), .timer_running_flag(run),
        .timer_interrupt_flag(tirq));
    ////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        if (fails == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // write through the host, then mirror into the model
    task automatic wm(input int ad, input int d);
        u_rcfg_host_model.wr(ad[7:0], d[7:0]);
        if (msk[ad] != 0)
            // gain register drops its reserved reset bits on a write
            exp_v[ad] = (exp_v[ad] & ~msk[ad] & ((ad == 'h26) ? 0 : 'hff))
                        | (d & msk[ad]);
    endtask
    task automatic rc(input int ad);
        u_rcfg_host_model.rd(ad[7:0], v);
        `CHK("rdata", exp_v[ad][7:0], v)
    endtask
    // one-cycle pulses on the receive-bit or the transmit-end input
    task automatic pulse(input bit rx, input int n);
        repeat (n) begin
            @(posedge core_clk) if (rx) rx_bit <= 1; else tx_end <= 1;
            @(posedge core_clk) begin rx_bit <= 0; tx_end <= 0; end
        end
        repeat (4) @(posedge core_clk);
    endtask
    initial
    begin
        repeat (20000) @(posedge core_clk);
        fails++;
        stop_test;
    end
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        foreach (exp_v[k]) begin exp_v[k] = 0; msk[k] = 0; end
        exp_v['h1c] = 'h62; exp_v['h1f] = 'heb; exp_v['h21] = 'hff;
        exp_v['h22] = 'hff; exp_v['h23] = 'h88; exp_v['h24] = 'h26;
        exp_v['h25] = 'h87; exp_v['h26] = 'h48; exp_v['h27] = 'h88;
        exp_v['h28] = 'h20; exp_v['h29] = 'h20;
        msk['h1c] = 'h03; msk['h1d] = 'h10; msk['h26] = 'h70;
        msk['h28] = 'h3f; msk['h29] = 'h3f;
        foreach (msk[k]) if (k inside {'h19, 'h1f, 'h24, 'h27, ['h2a:'h2d]}) msk[k] = 'hff;
        repeat (10) @(posedge core_clk);
        resetn <= 1'b1;
        // reset values, then random writes incl. reserved and read-only
        for (a = 'h19; a <= 'h2d; a++) rc(a);
        rc('h40);
        for (i = 0; i < 60; i++) begin
            a = 'h19 + ($unsigned($random(seed)) % 21);
            wm(a, $random(seed) & ((a == 'h2a) ? 'h7f : 'hff));
            rc(a);
        end
        // checksum bytes valid once the done flag is up
        @(posedge core_clk) begin ck_val <= 16'h5a3c; ck_ld <= 1; ck_done <= 1; end
        @(posedge core_clk) ck_ld <= 0;
        exp_v['h21] = 'h5a; exp_v['h22] = 'h3c;
        rc('h21); rc('h22);
        // field outputs, soft power-down forces top bits
        spd <= 1;
        wm('h1c, 'h01); wm('h1d, 'h10); wm('h1f, 'ha5); wm('h24, 'h37);
        wm('h27, 'h35); wm('h28, 'h05); wm('h19, 'h6b); wm('h29, 'h1a);
        repeat (3) @(posedge core_clk);
        `CHK("loop", 5'h0e, {pll, bls, rls})
        `CHK("p_mod", 7'h3a, {fask, p_mod})
        `CHK("ert", 2'h1, ert)
        `CHK("par", 1'b1, par)
        `CHK("rate", 8'ha5, {coarse, fine})
        `CHK("pw", 8'h37, pw)
        `CHK("n_drv", 8'hbd, {n_idle, n_mod})
        `CHK("p_idle", 6'h25, p_idle)
        `CHK("chan", 2'h3, {q_ch, fix})
        wm('h0c, 'h01); wm('h19, 'h43);
        repeat (3) @(posedge core_clk);
        `CHK("p_mod", 7'h60, {fask, p_mod})
        `CHK("loop", 5'h1c, {pll, bls, rls})
        for (i = 0; i < 8; i++) begin
            wm('h26, i << 4);
            repeat (3) @(posedge core_clk);
            `CHK("gain", db[i][5:0], gain)
        end
        // timer: protocol start and stop
        wm('h2b, 0); wm('h2c, 'hff); wm('h2d, 'hff); wm('h2a, 'h80);
        pulse(0, 1);
        `CHK("run", 1'b1, run)
        pulse(1, 4);
        `CHK("run", 1'b1, run)
        pulse(1, 1);
        `CHK("run", 1'b0, run)
        mfr <= 1;
        pulse(0, 1);
        pulse(1, 6);
        `CHK("run", 1'b1, run)
        wm('h0c, 'h80);
        repeat (3) @(posedge core_clk);
        `CHK("run", 1'b0, run)
        wm('h2a, 'h00);
        pulse(0, 1);
        `CHK("run", 1'b0, run)
        wm('h2d, 'h03); wm('h2c, 'h00); wm('h0c, 'h40);
        repeat (40) @(posedge core_clk);
        `CHK("tirq", 2'h1, {run, tirq})
        exp_v['h08] = 'h21;
        rc('h08);
        wm('h08, 'h01);
        exp_v['h08] = 'h20;
        rc('h08);
        stop_test;
    end
endmodule // reader_config_timer_regs_tb
